// file: logic/isr_pkg.sv
/*
  Shared constants for the status reporting and communication settings bank:
  register indices, field positions, reset values, settings limits.
  Assumes a command decoder upstream that turns host text into
  register-index accesses.
*/
`default_nettype none
package isr_pkg;
  localparam int ISR_DATA_W = 16;
  localparam int ISR_IDX_W = 5;

  // Register indices, one per settable or queryable item
  localparam logic [4:0] IDX_OPERATION_CONDITION = 5'h00;
  localparam logic [4:0] IDX_OPER_MASK = 5'h01;
  localparam logic [4:0] IDX_OPER_EVENT = 5'h02;
  localparam logic [4:0] IDX_OPER_FALL = 5'h03;
  localparam logic [4:0] IDX_OPER_RISE = 5'h04;
  localparam logic [4:0] IDX_QUES_EVENT = 5'h05;
  localparam logic [4:0] IDX_QUES_COND = 5'h06;
  localparam logic [4:0] IDX_QUES_MASK = 5'h07;
  localparam logic [4:0] IDX_BUS_ADDR = 5'h08;
  localparam logic [4:0] IDX_ECHO = 5'h09;
  localparam logic [4:0] IDX_NET_ADDR_HI = 5'h0A;
  localparam logic [4:0] IDX_NET_ADDR_LO = 5'h0B;
  localparam logic [4:0] IDX_SUBNET_HI = 5'h0C;
  localparam logic [4:0] IDX_SUBNET_LO = 5'h0D;
  localparam logic [4:0] IDX_HW_ADDR_0 = 5'h0E;
  localparam logic [4:0] IDX_HW_ADDR_1 = 5'h0F;
  localparam logic [4:0] IDX_HW_ADDR_2 = 5'h10;
  localparam logic [4:0] IDX_ADDR_MODE = 5'h11;
  localparam logic [4:0] IDX_DAMPING = 5'h12;
  localparam logic [4:0] IDX_BUS_ADDR_ACTIVE = 5'h13;

  // Operation group bit positions
  localparam int OPER_POWERED_UP_BIT = 7;
  localparam int OPER_CMD_ERR_BIT = 5;
  localparam int OPER_EXEC_ERR_BIT = 4;
  localparam int OPER_DEV_ERR_BIT = 3;
  localparam int OPER_QUERY_ERR_BIT = 2;
  localparam logic [15:0] OPER_USED_MASK = 16'h00BC;
  localparam logic [15:0] QUES_USED_MASK = 16'hFFFF;

  // Status byte summary positions
  localparam int STB_OPER_SUM_BIT = 7;
  localparam int STB_QUES_SUM_BIT = 3;

  // Settings limits and reset values
  localparam logic [4:0] BUS_ADDR_MIN = 5'h01;
  localparam logic [4:0] BUS_ADDR_MAX = 5'h1E;
  localparam logic [4:0] BUS_ADDR_RESET = 5'h0A;
  localparam logic [2:0] DAMP_MAX_NEW = 3'h7;
  localparam logic [2:0] DAMP_MAX_OLD = 3'h5;
  localparam logic [2:0] DAMP_RESET = 3'h4;
  localparam logic [15:0] DYN_NET_PREFIX = 16'hC0A8;

  typedef enum logic {
    ISR_MODE_STATIC,
    ISR_MODE_DYNAMIC
  } isr_addr_mode_e;

  typedef enum logic [1:0] {
    ISR_ST_IDLE,
    ISR_ST_READ,
    ISR_ST_REPLY
  } isr_state_e;
endpackage
`default_nettype wire

// file: logic/isr_settings_mem.sv
/*
  Small settings store for the four octet words of network address and
  subnet mask. Read data are registered.
  Assumes one write or one read per cycle from the owning bank.
*/
`timescale 1ns/10ps
`default_nettype none
module isr_settings_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Access
  input wire logic i_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] i_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic [WIDTH-1:0] o_rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_reg;
  logic [WIDTH-1:0] rd_next;

  always_comb begin
    rd_next = mem_reg[i_addr];
    for (int k = 0; k < DEPTH; k++) begin
      mem_next[k] = mem_reg[k];
    end
    if (i_wr_en) begin
      mem_next[i_addr] = i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rd_reg <= '0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= '0;
      end
    end else begin
      rd_reg <= rd_next;
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= mem_next[k];
      end
    end
  end

  assign o_rd_data = rd_reg;
endmodule
`default_nettype wire

// file: logic/isr_status_bank.sv
/*
  Status reporting and communication settings bank: operation and
  questionable groups with summary bits, plus stored interface settings.
  Assumes an upstream parser that presents decoded accesses as a one-cycle
  request with a register index, and tells which link it came from.
*/
`timescale 1ns/10ps
`default_nettype none
module isr_status_bank
  import isr_pkg::*;
#(
  parameter logic [47:0] HW_ADDR = 48'h02_00_00_00_00_01  // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Host access, one-cycle request
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic i_from_bus_link,
  input wire logic [4:0] i_idx,
  input wire logic [15:0] i_wdata,
  output logic o_ack,
  output logic o_invalid,
  output logic [15:0] o_rdata,
  // Live conditions and error pulses
  input wire logic [15:0] i_operation_condition,
  input wire logic [15:0] i_ques_cond,
  input wire logic [15:0] i_ques_event,
  input wire logic i_cmd_err,
  input wire logic i_exec_err,
  input wire logic i_dev_err,
  input wire logic i_query_err,
  // Configuration
  input wire logic i_net_option,
  input wire logic i_old_firmware,
  // Status and settings outputs
  output logic o_oper_summary,
  output logic o_ques_summary,
  output logic [4:0] o_bus_addr,
  output logic o_echo_en,
  output logic o_dynamic_mode,
  output logic [2:0] o_damping
);
  logic [15:0] oper_mask_reg, oper_mask_next;
  logic [15:0] oper_event_reg, oper_event_next;
  logic [15:0] fall_reg, fall_next;
  logic [15:0] rise_reg, rise_next;
  logic [15:0] cond_prev_reg, cond_prev_next;
  logic [15:0] ques_event_reg, ques_event_next;
  logic [15:0] ques_mask_reg, ques_mask_next;
  logic [4:0] addr_store_reg, addr_store_next;
  logic [4:0] addr_active_reg, addr_active_next;
  logic echo_reg, echo_next;
  isr_addr_mode_e mode_reg, mode_next;
  logic [2:0] damp_reg, damp_next;
  logic ack_reg, ack_next;
  logic inv_reg, inv_next;
  logic [15:0] rdata_reg, rdata_next;
  logic oper_sum_reg, oper_sum_next;
  logic ques_sum_reg, ques_sum_next;
  isr_state_e state_reg, state_next;
  logic [4:0] held_idx_reg, held_idx_next;
  logic [15:0] operation_condition_m1, operation_condition_s;
  logic [15:0] ques_cond_m1, ques_cond_s;
  logic mem_wr;
  logic [1:0] mem_addr;
  logic [15:0] mem_rd;
  logic [15:0] err_set;
  logic [15:0] edge_set;
  logic rd_oper_event, rd_ques_event, wr_ok, rd_ok, bus_cmd;

  // Live conditions come from other domains; synchronise first
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      operation_condition_m1 <= '0;
      operation_condition_s <= '0;
      ques_cond_m1 <= '0;
      ques_cond_s <= '0;
    end else begin
      operation_condition_m1 <= i_operation_condition;
      operation_condition_s <= operation_condition_m1;
      ques_cond_m1 <= i_ques_cond;
      ques_cond_s <= ques_cond_m1;
    end
  end

  assign mem_wr = i_req && i_wr && (i_idx >= IDX_NET_ADDR_HI) && (i_idx <= IDX_SUBNET_LO);
  assign mem_addr = mem_wr ? i_idx[1:0] - 2'h2 : held_idx_reg[1:0] - 2'h2;

  // Octet words, two octets per entry
  isr_settings_mem #(.WIDTH(16), .DEPTH(4)) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_wr_en(mem_wr),
    .i_addr(mem_addr),
    .i_wr_data(i_wdata),
    .o_rd_data(mem_rd)
  );

  always_comb begin
    bus_cmd = (i_idx == IDX_BUS_ADDR) || (i_idx == IDX_BUS_ADDR_ACTIVE);
    wr_ok = i_req && i_wr && !(bus_cmd && i_from_bus_link);
    rd_ok = i_req && !i_wr && !(bus_cmd && i_from_bus_link);
    rd_oper_event = rd_ok && (i_idx == IDX_OPER_EVENT);
    rd_ques_event = rd_ok && (i_idx == IDX_QUES_EVENT);
    err_set = '0;
    err_set[OPER_CMD_ERR_BIT] = i_cmd_err;
    err_set[OPER_EXEC_ERR_BIT] = i_exec_err;
    err_set[OPER_DEV_ERR_BIT] = i_dev_err;
    err_set[OPER_QUERY_ERR_BIT] = i_query_err;
    // Filtered edges of the live condition
    edge_set = ((operation_condition_s & ~cond_prev_reg) & rise_reg)
             | ((~operation_condition_s & cond_prev_reg) & fall_reg);
    cond_prev_next = operation_condition_s;
    // Set wins over read-clear so no event is lost
    oper_event_next = (rd_oper_event ? 16'h0000 : oper_event_reg)
                    | ((err_set | edge_set) & OPER_USED_MASK);
    ques_event_next = (rd_ques_event ? 16'h0000 : ques_event_reg) | i_ques_event;
    oper_mask_next = oper_mask_reg;
    fall_next = fall_reg;
    rise_next = rise_reg;
    ques_mask_next = ques_mask_reg;
    addr_store_next = addr_store_reg;
    addr_active_next = addr_active_reg;
    echo_next = echo_reg;
    mode_next = mode_reg;
    damp_next = damp_reg;
    if (wr_ok) begin
      unique case (i_idx)
        IDX_OPER_MASK: oper_mask_next = i_wdata & OPER_USED_MASK;
        IDX_OPER_FALL: fall_next = i_wdata & OPER_USED_MASK;
        IDX_OPER_RISE: rise_next = i_wdata & OPER_USED_MASK;
        IDX_QUES_MASK: ques_mask_next = i_wdata & QUES_USED_MASK;
        IDX_BUS_ADDR: begin
          if ((i_wdata[4:0] >= BUS_ADDR_MIN) && (i_wdata[4:0] <= BUS_ADDR_MAX)
              && (i_wdata[15:5] == 11'h000)) begin
            addr_store_next = i_wdata[4:0];
          end
        end
        IDX_ECHO: echo_next = i_wdata[0];
        IDX_ADDR_MODE: mode_next = i_wdata[0] ? ISR_MODE_DYNAMIC : ISR_MODE_STATIC;
        IDX_DAMPING: begin
          if ((i_wdata[15:3] == 13'h0000)
              && (i_wdata[2:0] <= (i_old_firmware ? DAMP_MAX_OLD : DAMP_MAX_NEW))) begin
            damp_next = i_wdata[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Reply path: most reads answer next cycle, octet reads wait two more
  always_comb begin
    state_next = state_reg;
    held_idx_next = held_idx_reg;
    ack_next = 1'b0;
    inv_next = 1'b0;
    rdata_next = rdata_reg;
    unique case (state_reg)
      ISR_ST_IDLE: begin
        if (i_req) begin
          held_idx_next = i_idx;
          if (i_req && bus_cmd && i_from_bus_link) begin
            ack_next = 1'b1;
            inv_next = 1'b1;
            rdata_next = 16'h0000;
          end else if (!i_wr && (i_idx >= IDX_NET_ADDR_HI) && (i_idx <= IDX_SUBNET_LO)) begin
            state_next = ISR_ST_READ;
          end else begin
            ack_next = 1'b1;
            rdata_next = 16'h0000;
            if (!i_wr) begin
              unique case (i_idx)
                IDX_OPERATION_CONDITION: rdata_next = operation_condition_s & OPER_USED_MASK;
                IDX_OPER_MASK: rdata_next = oper_mask_reg;
                IDX_OPER_EVENT: rdata_next = oper_event_reg;
                IDX_OPER_FALL: rdata_next = fall_reg;
                IDX_OPER_RISE: rdata_next = rise_reg;
                IDX_QUES_EVENT: rdata_next = ques_event_reg;
                IDX_QUES_COND: rdata_next = ques_cond_s;
                IDX_QUES_MASK: rdata_next = ques_mask_reg;
                IDX_BUS_ADDR: rdata_next = {11'h000, addr_store_reg};
                IDX_BUS_ADDR_ACTIVE: rdata_next = {11'h000, addr_active_reg};
                IDX_ECHO: rdata_next = {15'h0000, echo_reg};
                IDX_HW_ADDR_0: rdata_next = i_net_option ? HW_ADDR[15:0] : 16'h0000;
                IDX_HW_ADDR_1: rdata_next = i_net_option ? HW_ADDR[31:16] : 16'h0000;
                IDX_HW_ADDR_2: rdata_next = i_net_option ? HW_ADDR[47:32] : 16'h0000;
                IDX_ADDR_MODE: rdata_next = {15'h0000, mode_reg == ISR_MODE_DYNAMIC};
                IDX_DAMPING: rdata_next = {13'h0000, damp_reg};
                default: inv_next = 1'b1;
              endcase
            end else if (i_idx > IDX_DAMPING) begin
              inv_next = 1'b1;
            end
          end
        end
      end
      ISR_ST_READ: state_next = ISR_ST_REPLY;
      ISR_ST_REPLY: begin
        ack_next = 1'b1;
        // Dynamic mode reports the fixed private prefix in the network address high octets
        if ((mode_reg == ISR_MODE_DYNAMIC) && (held_idx_reg == IDX_NET_ADDR_HI)) begin
          rdata_next = DYN_NET_PREFIX;
        end else begin
          rdata_next = mem_rd;
        end
        state_next = ISR_ST_IDLE;
      end
      default: state_next = ISR_ST_IDLE;
    endcase
    // Summaries recomputed every cycle
    oper_sum_next = |(oper_event_next & oper_mask_next);
    ques_sum_next = |(ques_event_next & ques_mask_next);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      oper_mask_reg <= 16'h0000;
      oper_event_reg <= 16'h0080;  // Powered-up flag
      fall_reg <= 16'h0000;
      rise_reg <= 16'h0000;
      cond_prev_reg <= 16'h0000;
      ques_event_reg <= 16'h0000;
      ques_mask_reg <= 16'h0000;
      addr_store_reg <= BUS_ADDR_RESET;
      addr_active_reg <= BUS_ADDR_RESET;  // Loads BUS_ADDR_RESET, never the stored copy, and then never changes
      echo_reg <= 1'b0;
      mode_reg <= ISR_MODE_STATIC;
      damp_reg <= DAMP_RESET;
      ack_reg <= 1'b0;
      inv_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      oper_sum_reg <= 1'b0;
      ques_sum_reg <= 1'b0;
      state_reg <= ISR_ST_IDLE;
      held_idx_reg <= 5'h00;
    end else begin
      oper_mask_reg <= oper_mask_next;
      oper_event_reg <= oper_event_next;
      fall_reg <= fall_next;
      rise_reg <= rise_next;
      cond_prev_reg <= cond_prev_next;
      ques_event_reg <= ques_event_next;
      ques_mask_reg <= ques_mask_next;
      addr_store_reg <= addr_store_next;
      addr_active_reg <= addr_active_next;
      echo_reg <= echo_next;
      mode_reg <= mode_next;
      damp_reg <= damp_next;
      ack_reg <= ack_next;
      inv_reg <= inv_next;
      rdata_reg <= rdata_next;
      oper_sum_reg <= oper_sum_next;
      ques_sum_reg <= ques_sum_next;
      state_reg <= state_next;
      held_idx_reg <= held_idx_next;
    end
  end

  assign o_ack = ack_reg;
  assign o_invalid = inv_reg;
  assign o_rdata = rdata_reg;
  assign o_oper_summary = oper_sum_reg;
  assign o_ques_summary = ques_sum_reg;
  assign o_bus_addr = addr_active_reg;
  assign o_echo_en = echo_reg;
  assign o_dynamic_mode = (mode_reg == ISR_MODE_DYNAMIC);
  assign o_damping = damp_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_oper_sum_or: assert property (o_oper_summary == |(oper_event_reg & oper_mask_reg))
    else $error("operation summary mismatch");
  a_ques_sum_or: assert property (o_ques_summary == |(ques_event_reg & ques_mask_reg))
    else $error("questionable summary mismatch");
  a_oper_unused_zero: assert property ((oper_event_reg & ~OPER_USED_MASK) == 16'h0000)
    else $error("unused operation bit set");
  a_event_read_clear: assert property (
    (rd_oper_event && !(|err_set) && !(|edge_set)) |=> oper_event_reg == 16'h0000)
    else $error("operation event not cleared by read");
  a_ques_read_clear: assert property (
    (rd_ques_event && i_ques_event == 16'h0000) |=> ques_event_reg == 16'h0000)
    else $error("questionable event not cleared by read");
  a_bus_addr_range: assert property (
    addr_store_reg >= BUS_ADDR_MIN && addr_store_reg <= BUS_ADDR_MAX)
    else $error("bus address out of range");
  a_bus_addr_held: assert property ($stable(addr_active_reg))
    else $error("active bus address changed");
  a_bus_link_refuse: assert property (
    (state_reg == ISR_ST_IDLE && i_req && bus_cmd && i_from_bus_link)
    |=> (o_ack && o_invalid))
    else $error("bus address command not refused");
  // Limit applies when a new value is taken, not to a value kept from before
  a_damp_range: assert property (
    !$stable(damp_reg) |-> damp_reg <= ($past(i_old_firmware) ? DAMP_MAX_OLD : DAMP_MAX_NEW))
    else $error("damping out of range");
  a_error_latch: assert property (i_cmd_err |=> oper_event_reg[OPER_CMD_ERR_BIT])
    else $error("command error not latched");
  a_octet_reply: assert property (
    (state_reg == ISR_ST_IDLE && i_req && !i_wr && !bus_cmd
     && i_idx >= IDX_NET_ADDR_HI && i_idx <= IDX_SUBNET_LO)
    |=> !o_ack ##1 !o_ack ##1 o_ack)
    else $error("octet reply timing");

  c_oper_summary: cover property ($rose(o_oper_summary));
  c_ques_summary: cover property ($rose(o_ques_summary));
  c_refused: cover property (o_invalid);
  c_octet_read: cover property (state_reg == ISR_ST_REPLY);
endmodule
`default_nettype wire

// file: tb/isr_host_model.sv
/*
  Host controller model: issues one-cycle register requests to the status
  bank and collects the answer.
  Assumes every caller enters xfer on a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module isr_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Request side
  output logic o_req,
  output logic o_wr,
  output logic o_from_bus_link,
  output logic [4:0] o_idx,
  output logic [15:0] o_wdata,
  // Answer side
  input wire logic i_ack,
  input wire logic i_invalid,
  input wire logic [15:0] i_rdata
);
  initial begin
    o_req = 1'h0;
    o_wr = 1'h0;
    o_from_bus_link = 1'h0;
    o_idx = 5'h00;
    o_wdata = 16'h0000;
  end

  // Gives up after four cycles without an answer and clears ok
  task automatic xfer(input logic w, input logic lk, input logic [4:0] ix,
                      input logic [15:0] d, output logic [15:0] rd,
                      output logic iv, output logic ok);
    int n;
    o_req <= 1'h1;
    o_wr <= w;
    o_from_bus_link <= lk;
    o_idx <= ix;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_req <= 1'h0;
    // Released index and data lines carry junk, so stale values cannot pass a check
    o_idx <= ~ix;
    o_wdata <= ~d;
    ok = 1'h0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge i_clk_sys);
      ok = (i_ack === 1'h1);
    end
    rd = i_rdata;
    iv = i_invalid;
  endtask
endmodule
`default_nettype wire

// file: tb/isr_status_bank_test.sv
/*
  Self-checking bench for the status bank: table of plain accesses, then
  hand-written cases for limits, refusals, events and a second reset.
  Assumes the host model for all register traffic.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module isr_status_bank_test;
  import isr_pkg::*;
  typedef struct packed {
    logic wr;
    logic [4:0] idx;
    logic [15:0] wd;
    logic [15:0] ex;
    logic inv;
  } isr_row_s;
  localparam logic [47:0] HWA = 48'h0A1B_2C3D_4E5F; // Arbitrary value
  logic clk, srst, req, wr, lnk, ack, inv, net_opt, old_fw;
  logic oper_sum, ques_sum, echo, dyn;
  logic [4:0] idx, bus_addr;
  logic [2:0] damp;
  logic [3:0] errs;
  logic [15:0] wdata, rdata, operation_condition, ques_cond, ques_ev;
  int err_count = 0;
  int num_checks = 0;
  isr_row_s rows [18] = '{
    {1'h0, IDX_OPER_EVENT, 16'h0000, 16'h0080, 1'h0},
    {1'h0, IDX_OPER_EVENT, 16'h0000, 16'h0000, 1'h0},
    {1'h1, IDX_OPER_MASK, 16'hFFFF, 16'h0000, 1'h0},
    {1'h0, IDX_OPER_MASK, 16'h0000, 16'h00BC, 1'h0},
    {1'h1, IDX_QUES_MASK, 16'hFFFF, 16'h0000, 1'h0},
    {1'h0, IDX_QUES_MASK, 16'h0000, 16'hFFFF, 1'h0},
    {1'h0, IDX_BUS_ADDR, 16'h0000, 16'h000A, 1'h0},
    {1'h0, IDX_ECHO, 16'h0000, 16'h0000, 1'h0},
    {1'h1, IDX_ECHO, 16'h0001, 16'h0000, 1'h0},
    {1'h0, IDX_ECHO, 16'h0000, 16'h0001, 1'h0},
    {1'h1, IDX_NET_ADDR_HI, 16'hFF00, 16'h0000, 1'h0},
    {1'h1, IDX_SUBNET_LO, 16'h01FE, 16'h0000, 1'h0},
    {1'h0, IDX_NET_ADDR_HI, 16'h0000, 16'hFF00, 1'h0},
    {1'h0, IDX_SUBNET_LO, 16'h0000, 16'h01FE, 1'h0},
    {1'h0, IDX_ADDR_MODE, 16'h0000, 16'h0000, 1'h0},
    {1'h0, IDX_DAMPING, 16'h0000, 16'h0004, 1'h0},
    {1'h0, IDX_HW_ADDR_0, 16'h0000, 16'h0000, 1'h0},
    {1'h0, 5'h1F, 16'h0000, 16'h0000, 1'h1}
  };

  isr_status_bank #(.HW_ADDR(HWA)) i_isr_status_bank (
    .i_clk_sys(clk), .i_srst(srst), .i_req(req), .i_wr(wr),
    .i_from_bus_link(lnk), .i_idx(idx), .i_wdata(wdata), .o_ack(ack),
    .o_invalid(inv), .o_rdata(rdata), .i_operation_condition(operation_condition),
    .i_ques_cond(ques_cond), .i_ques_event(ques_ev), .i_cmd_err(errs[3]),
    .i_exec_err(errs[2]), .i_dev_err(errs[1]), .i_query_err(errs[0]),
    .i_net_option(net_opt), .i_old_firmware(old_fw),
    .o_oper_summary(oper_sum), .o_ques_summary(ques_sum),
    .o_bus_addr(bus_addr), .o_echo_en(echo), .o_dynamic_mode(dyn),
    .o_damping(damp)
  );

  isr_host_model i_isr_host_model (
    .i_clk_sys(clk), .o_req(req), .o_wr(wr), .o_from_bus_link(lnk),
    .o_idx(idx), .o_wdata(wdata), .i_ack(ack), .i_invalid(inv),
    .i_rdata(rdata)
  );

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Refused answers read back as zero, but only the flag is checked for them
  task automatic acc(input logic w, input logic lk, input logic [4:0] ix,
                     input logic [15:0] d, input logic [15:0] ex, input logic ei);
    logic [15:0] rd;
    logic iv, ok;
    i_isr_host_model.xfer(w, lk, ix, d, rd, iv, ok);
    `CHK(ok, 1'h1)
    `CHK(iv, ei)
    if (!ei) `CHK(rd, ex)
  endtask

  task automatic wreg(input logic [4:0] ix, input logic [15:0] d);
    acc(1'h1, 1'h0, ix, d, 16'h0000, 1'h0);
  endtask

  task automatic rreg(input logic [4:0] ix, input logic [15:0] ex);
    acc(1'h0, 1'h0, ix, 16'h0000, ex, 1'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    srst = 1'h1;
    net_opt = 1'h0;
    old_fw = 1'h0;
    errs = 4'h0;
    operation_condition = 16'h0000;
    ques_cond = 16'h0000;
    ques_ev = 16'h0000;
    cyc(6);
    srst <= 1'h0;
    `CHK(bus_addr, BUS_ADDR_RESET)
    `CHK(damp, DAMP_RESET)
    `CHK(oper_sum, 1'h0)
    foreach (rows[k]) acc(rows[k].wr, 1'h0, rows[k].idx, rows[k].wd, rows[k].ex, rows[k].inv);
    `CHK(echo, 1'h1)
    acc(1'h1, 1'h1, IDX_BUS_ADDR, 16'h0005, 16'h0000, 1'h1);
    acc(1'h0, 1'h1, IDX_BUS_ADDR_ACTIVE, 16'h0000, 16'h0000, 1'h1);
    wreg(IDX_BUS_ADDR, 16'h0000);
    wreg(IDX_BUS_ADDR, 16'h001F);
    rreg(IDX_BUS_ADDR, 16'h000A);
    wreg(IDX_BUS_ADDR, 16'h001E);
    rreg(IDX_BUS_ADDR, 16'h001E);
    rreg(IDX_BUS_ADDR_ACTIVE, 16'h000A);
    `CHK(bus_addr, BUS_ADDR_RESET)
    wreg(IDX_DAMPING, 16'h0008);
    wreg(IDX_DAMPING, 16'h0007);
    rreg(IDX_DAMPING, 16'h0007);
    old_fw <= 1'h1;
    wreg(IDX_DAMPING, 16'h0006);
    rreg(IDX_DAMPING, 16'h0007);
    wreg(IDX_DAMPING, 16'h0005);
    `CHK(damp, 3'h5)
    net_opt <= 1'h1;
    for (int k = 0; k < 3; k++) rreg(IDX_HW_ADDR_0 + 5'(k), HWA[16*k +: 16]);
    wreg(IDX_ADDR_MODE, 16'h0001);
    `CHK(dyn, 1'h1)
    rreg(IDX_NET_ADDR_HI, DYN_NET_PREFIX);
    wreg(IDX_OPER_MASK, 16'h0010);
    for (int k = 0; k < 4; k++) begin
      errs <= 4'h8 >> k;
      @(posedge clk);
      errs <= 4'h0;
      cyc(3);
      `CHK(oper_sum, k == 1)
      rreg(IDX_OPER_EVENT, 16'h0020 >> k);
    end
    wreg(IDX_OPER_RISE, 16'h0020);
    wreg(IDX_OPER_FALL, 16'h0004);
    operation_condition <= 16'hFF24;
    cyc(5);
    rreg(IDX_OPERATION_CONDITION, 16'h0024);
    rreg(IDX_OPER_EVENT, 16'h0020);
    operation_condition <= 16'h0000;
    cyc(5);
    rreg(IDX_OPER_EVENT, 16'h0004);
    ques_cond <= 16'hA5C3;
    cyc(4);
    rreg(IDX_QUES_COND, 16'hA5C3);
    wreg(IDX_QUES_MASK, 16'h8000);
    ques_ev <= 16'h0101;
    @(posedge clk);
    ques_ev <= 16'h0000;
    cyc(3);
    `CHK(ques_sum, 1'h0)
    rreg(IDX_QUES_EVENT, 16'h0101);
    rreg(IDX_QUES_EVENT, 16'h0000);
    ques_ev <= 16'h8000;
    @(posedge clk);
    ques_ev <= 16'h0000;
    cyc(3);
    `CHK(ques_sum, 1'h1)
    rreg(IDX_QUES_EVENT, 16'h8000);
    cyc(2);
    `CHK(ques_sum, 1'h0)
    srst <= 1'h1;
    cyc(2);
    srst <= 1'h0;
    `CHK(damp, DAMP_RESET)
    `CHK(echo, 1'h0)
    `CHK(dyn, 1'h0)
    rreg(IDX_OPER_EVENT, 16'h0080);
    end_of_test();
  end
endmodule
`default_nettype wire
